// ### include/clkctl_pkg.sv
// Purpose: shared constants and types for the clock, enable and reset control block
// Assumes: 200 MHz core clock, register port with one-cycle read latency
// Notes: offsets are word indices on the plain register port
package clkctl_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [3:0] OFF_CLK_DIVIDER = 4'h0;
	localparam logic [3:0] OFF_SETPOINT0 = 4'h1;
	localparam logic [3:0] OFF_SETPOINT1 = 4'h2;
	localparam logic [3:0] OFF_DIAGNOSIS = 4'h3;
	localparam logic [3:0] OFF_CONFIG = 4'h4;
	localparam logic [3:0] OFF_VERSION = 4'h5;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int DIV_RATIO_LSB = 0;
	localparam int DIV_RATIO_W = 6;
	localparam int DIV_CLOCK_WATCHDOG_ENABLE_BIT = 15;
	localparam int SP_EN_BIT = 15;
	localparam int SP_VALUE_W = 15;
	localparam int DIAG_RST_BIT = 0;
	localparam int DIAG_FLT_BIT = 1;
	localparam int CFG_FME_BIT = 0;
	localparam int VER_WD_BIT = 15;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [5:0] DIV_RATIO_RESET = 6'h08;
	localparam logic [14:0] VERSION_ID = 15'h0A5A; // Arbitrary identity value
	localparam int CORE_CLK_MHZ = 200;
	localparam int CLOCK_MISSING_TIMEOUT_NS = 1000;
	localparam int CLOCK_MISSING_CYCLES = (CLOCK_MISSING_TIMEOUT_NS * CORE_CLK_MHZ) / 1000;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_WD_LOST,
		ST_WD_BACK
	} wd_state_type;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;

endpackage

// ### logic/clock_monitor_enable_reset_ctrl.sv
// Purpose: clock divider, missing-clock watchdog, enable and reset control
// Assumes: pins synchronous to clk; register port answers one cycle later
// Notes: watchdog internal reset is left only by ext_reset_n or power-on
`timescale 1ns/1ps
module clock_monitor_enable_reset_ctrl #(
	parameter int TIMEOUT = clkctl_pkg::CLOCK_MISSING_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Device pins
	input wire logic ext_clk,
	input wire logic ext_reset_n,
	input wire logic enable_pin,
	output logic fault_out_n,
	output logic fault_out_n_oe,
	// Fault source from diagnosis circuit
	input wire logic diag_fault,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Derived clocking and stage control
	output logic sys_clk_en,
	output logic [1:0] stage_enable,
	output logic internal_reset
);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	// Gap counter needs at least two cycles to tell slow from lost
	if (TIMEOUT < 2) begin : g_bad_timeout
		$error("clock_monitor_enable_reset_ctrl: TIMEOUT too small");
	end

	// ------------------------------------------------------------
	// Request bundle and decode
	// ------------------------------------------------------------
	clkctl_pkg::reg_req_type req;
	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	clkctl_pkg::wd_state_type wd_state_reg, wd_state_next;

	logic rise;
	logic missing;

	logic [5:0] div_ratio_reg;
	logic div_written_reg;
	logic clock_watchdog_enable_reg;
	logic [1:0] ch_en_reg;
	logic [14:0] sp_value_reg [2];
	logic fme_reg;
	logic rst_flag_reg;
	logic wd_status_reg;
	logic [5:0] div_cnt_reg;
	logic [15:0] rdata_reg;
	logic ext_reset_seen_reg;

	wire hold_reset = ~ext_reset_n;
	wire wd_tripped = (wd_state_reg != clkctl_pkg::ST_RUN);
	wire wd_trip = (wd_state_reg == clkctl_pkg::ST_RUN) && clock_watchdog_enable_reg && missing;
	wire in_reset = hold_reset | wd_tripped;
	wire port_live = ~hold_reset;
	// Writes refused in both tripped states
	wire wr_ok = req.wr & port_live & ~wd_tripped;
	// Address hits, shared by write decode and read select
	wire hit_div = (req.addr == clkctl_pkg::OFF_CLK_DIVIDER);
	wire hit_sp0 = (req.addr == clkctl_pkg::OFF_SETPOINT0);
	wire hit_sp1 = (req.addr == clkctl_pkg::OFF_SETPOINT1);
	wire hit_diag = (req.addr == clkctl_pkg::OFF_DIAGNOSIS);
	wire hit_cfg = (req.addr == clkctl_pkg::OFF_CONFIG);
	wire hit_ver = (req.addr == clkctl_pkg::OFF_VERSION);
	wire wr_div = wr_ok && hit_div;
	wire wr_sp0 = wr_ok && hit_sp0;
	wire wr_sp1 = wr_ok && hit_sp1;
	wire wr_cfg = wr_ok && hit_cfg;
	wire diag_access = port_live && hit_diag && (req.wr | req.rd);
	wire [1:0] wr_sp = {wr_sp1, wr_sp0};

	// ------------------------------------------------------------
	// Missing clock detector
	// ------------------------------------------------------------
	edge_watch #(
		.TIMEOUT(TIMEOUT)
	) u_watch (
		.clk(clk),
		.reset(reset | hold_reset),
		.ext_clk(ext_clk),
		.rise(rise),
		.missing(missing)
	);

	// ------------------------------------------------------------
	// Watchdog state
	// ------------------------------------------------------------
	always_comb begin
		wd_state_next = wd_state_reg;
		unique case (wd_state_reg)
			clkctl_pkg::ST_RUN: begin
				if (wd_trip) begin
					wd_state_next = clkctl_pkg::ST_WD_LOST;
				end
			end
			clkctl_pkg::ST_WD_LOST: begin
				if (!missing) begin
					wd_state_next = clkctl_pkg::ST_WD_BACK;
				end
			end
			clkctl_pkg::ST_WD_BACK: begin
				if (missing) begin
					wd_state_next = clkctl_pkg::ST_WD_LOST;
				end
			end
			default: wd_state_next = clkctl_pkg::ST_RUN;
		endcase
	end

	// Only external or power-on reset leaves a trip
	always_ff @(posedge clk) begin
		if (reset || hold_reset) begin
			wd_state_reg <= clkctl_pkg::ST_RUN;
		end else begin
			wd_state_reg <= wd_state_next;
		end
	end

	// ------------------------------------------------------------
	// Divider register and supervision enable
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset || hold_reset || wd_tripped) begin
			div_ratio_reg <= clkctl_pkg::DIV_RATIO_RESET;
			div_written_reg <= 1'b0;
			clock_watchdog_enable_reg <= 1'b0;
		end else if (wr_div) begin
			div_ratio_reg <= req.wdata[clkctl_pkg::DIV_RATIO_LSB +: clkctl_pkg::DIV_RATIO_W];
			div_written_reg <= 1'b1;
			clock_watchdog_enable_reg <= req.wdata[clkctl_pkg::DIV_CLOCK_WATCHDOG_ENABLE_BIT];
		end
	end

	// ------------------------------------------------------------
	// System clock enable from input edges
	// ------------------------------------------------------------
	// One enable pulse per div_ratio rising edges of the input
	// Runs on through a trip, so a returned clock divides by eight
	wire div_wrap = (div_cnt_reg + 6'h01 >= div_ratio_reg);
	always_ff @(posedge clk) begin
		if (reset || hold_reset) begin
			div_cnt_reg <= 6'h00;
		end else if (rise) begin
			div_cnt_reg <= div_wrap ? 6'h00 : div_cnt_reg + 6'h01;
		end
	end
	assign sys_clk_en = rise & div_wrap & ~reset & ~hold_reset;

	// ------------------------------------------------------------
	// Setpoint registers
	// ------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_sp
			always_ff @(posedge clk) begin
				if (reset || hold_reset || wd_tripped) begin
					ch_en_reg[ch] <= 1'b0;
					sp_value_reg[ch] <= 15'h0000;
				end else begin
					if (wr_sp[ch]) begin
						sp_value_reg[ch] <= req.wdata[clkctl_pkg::SP_VALUE_W-1:0];
					end
					// Pin low wins over any write
					if (!enable_pin) begin
						ch_en_reg[ch] <= 1'b0;
					end else if (wr_sp[ch]) begin
						ch_en_reg[ch] <= req.wdata[clkctl_pkg::SP_EN_BIT];
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Configuration and flags
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset || hold_reset || wd_tripped) begin
			fme_reg <= 1'b0;
		end else if (wr_cfg) begin
			fme_reg <= req.wdata[clkctl_pkg::CFG_FME_BIT];
		end
	end

	// Status survives a trip, cleared only by a real reset
	always_ff @(posedge clk) begin
		if (reset || hold_reset) begin
			wd_status_reg <= 1'b0;
		end else if (wd_trip) begin
			wd_status_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ext_reset_seen_reg <= 1'b1;
		end else begin
			ext_reset_seen_reg <= in_reset;
		end
	end

	// Exit from reset sets the flag; set wins over a same-cycle access
	wire reset_exit = ext_reset_seen_reg & ~in_reset;
	always_ff @(posedge clk) begin
		if (reset) begin
			rst_flag_reg <= 1'b0;
		end else if (reset_exit) begin
			rst_flag_reg <= 1'b1;
		end else if (diag_access) begin
			rst_flag_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Stage enables and fault pin
	// ------------------------------------------------------------
	// Stages need divider written, supervision on, pin high, no reset
	wire stage_ok = div_written_reg & clock_watchdog_enable_reg & enable_pin & ~in_reset;
	assign stage_enable = stage_ok ? ch_en_reg : 2'b00;
	assign internal_reset = in_reset;

	// Trip fault unmaskable; enable fault only with mask bit
	// Power-on reset counts as internal reset for the pin
	wire fault_reset = reset | in_reset;
	wire fault_enable = ~enable_pin & fme_reg;
	wire fault_any = diag_fault | fault_reset | fault_enable;
	assign fault_out_n = 1'b0;
	assign fault_out_n_oe = fault_any;

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	wire [15:0] version_word = {wd_status_reg, clkctl_pkg::VERSION_ID};
	wire [15:0] div_word = {clock_watchdog_enable_reg, 9'h000, div_ratio_reg};
	wire [15:0] sp0_word = {ch_en_reg[0], sp_value_reg[0]};
	wire [15:0] sp1_word = {ch_en_reg[1], sp_value_reg[1]};
	wire [15:0] diag_word = {14'h0000, diag_fault, rst_flag_reg};
	wire [15:0] cfg_word = {15'h0000, fme_reg};
	// Control registers hold reset values while tripped, so reads give them in ST_WD_BACK
	wire [15:0] sel_word =
		hit_div ? div_word :
		hit_sp0 ? sp0_word :
		hit_sp1 ? sp1_word :
		hit_diag ? diag_word :
		hit_cfg ? cfg_word :
		hit_ver ? version_word : 16'h0000;
	// Lost clock answers every read with the version word
	wire lost = (wd_state_reg == clkctl_pkg::ST_WD_LOST);
	wire [15:0] answer = lost ? version_word : sel_word;

	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_reg <= 16'h0000;
		end else if (req.rd && port_live) begin
			rdata_reg <= answer;
		end else begin
			rdata_reg <= 16'h0000;
		end
	end
	assign reg_rdata = rdata_reg;

endmodule

// ### logic/edge_watch.sv
// Purpose: watches a sampled external clock for rising edges and for long gaps
// Assumes: ext clock already synchronous to clk
// Notes: timed by the core clock, never by the watched clock
`timescale 1ns/1ps
module edge_watch #(
	parameter int TIMEOUT = clkctl_pkg::CLOCK_MISSING_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Watched clock
	input wire logic ext_clk,
	// Results
	output logic rise,
	output logic missing
);
	localparam int CW = $clog2(TIMEOUT + 1);

	// Below two cycles a slow edge cannot be told from a lost clock
	if (TIMEOUT < 2) begin : g_bad_timeout
		$error("edge_watch: TIMEOUT too small");
	end

	logic prev_reg;
	logic [CW-1:0] gap_reg;
	logic missing_reg;
	wire at_limit = (gap_reg >= CW'(TIMEOUT));

	assign rise = ext_clk & ~prev_reg;
	assign missing = missing_reg;

	// Gap counted on the core clock so absence is measurable
	always_ff @(posedge clk) begin
		if (reset) begin
			prev_reg <= 1'b0;
			gap_reg <= '0;
			missing_reg <= 1'b0;
		end else begin
			prev_reg <= ext_clk;
			if (rise) begin
				gap_reg <= '0;
				missing_reg <= 1'b0;
			end else if (!at_limit) begin
				gap_reg <= gap_reg + CW'(1);
			end else begin
				missing_reg <= 1'b1;
			end
		end
	end
endmodule

// ### sim/clk_ctl_monitor.sv
// Purpose: port checks for the clock, enable and reset control
// Assumes: one clock domain, sync active-high reset
// Notes: gap count mirrors the watched clock on the core clock
`timescale 1ns/1ps
module clk_ctl_monitor #(
	parameter int TIMEOUT = 16
) (
	// Clock and pins
	input wire logic clk,
	input wire logic reset,
	input wire logic ext_clk,
	input wire logic ext_reset_n,
	input wire logic enable_pin,
	input wire logic diag_fault,
	input wire logic fault_out_n,
	input wire logic fault_out_n_oe,
	// Register read side
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Stage control
	input wire logic [1:0] stage_enable,
	input wire logic internal_reset
);
	logic ext_q;
	logic [9:0] gap;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ------------------------------------------------------------
	// Cycles since the last watched rising edge
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		ext_q <= ext_clk;
		if (reset || (ext_clk && !ext_q)) gap <= 10'h000;
		else if (gap != 10'h3FF) gap <= gap + 10'h001;
	end
	sequence trip_seen;
		$rose(internal_reset) && ext_reset_n;
	endsequence
	sequence trip_held;
		(internal_reset && ext_reset_n) [*2];
	endsequence
	a_fault_data_low: assert property (fault_out_n == 1'b0)
		else $error("fault data not low");
	a_fault_on_cause: assert property (diag_fault || internal_reset |-> fault_out_n_oe)
		else $error("fault pin not pulled");
	a_ext_reset_hold: assert property (!ext_reset_n [*2] |-> internal_reset && fault_out_n_oe)
		else $error("ext reset not held");
	a_dead_read_zero: assert property (!reg_rd || (!ext_reset_n && !$past(ext_reset_n))
		|=> reg_rdata == 16'h0000)
		else $error("read data not zero");
	a_stage_pin_off: assert property (!enable_pin |-> stage_enable == 2'b00)
		else $error("stage on with pin low");
	a_stage_trip_off: assert property (internal_reset |-> stage_enable == 2'b00)
		else $error("stage on in reset");
	a_stage_rise_zero: assert property ($rose(enable_pin) |-> stage_enable == 2'b00)
		else $error("stage on at pin rise");
	a_trip_after_gap: assert property (trip_seen |-> gap >= TIMEOUT)
		else $error("trip without gap");
	a_trip_sticky: assert property (trip_held |=> internal_reset)
		else $error("trip left alone");
endmodule

bind clock_monitor_enable_reset_ctrl clk_ctl_monitor #(.TIMEOUT(TIMEOUT)) i_mon (
	.clk(clk), .reset(reset), .ext_clk(ext_clk), .ext_reset_n(ext_reset_n),
	.enable_pin(enable_pin), .diag_fault(diag_fault), .fault_out_n(fault_out_n),
	.fault_out_n_oe(fault_out_n_oe), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.stage_enable(stage_enable), .internal_reset(internal_reset));

// ### sim/host_clock_source.sv
// Purpose: host pins for the watched clock and the reset pin
// Assumes: watched clock well below half the core clock
// Notes: a stopped clock rests low, as the pin pull-down holds it
`timescale 1ns/1ps
module host_clock_source #(
	parameter int HALF = 2
) (
	// Core clock and bench controls
	input wire logic clk,
	input wire logic run,
	input wire logic rst_req,
	// Pins
	output logic ext_clk,
	output logic ext_reset_n
);
	int cnt = 0;
	initial ext_clk = 1'b0;
	initial ext_reset_n = 1'b1;
	always @(posedge clk) begin
		ext_reset_n <= !rst_req;
		cnt <= (cnt + 1) % HALF;
		if (!run) ext_clk <= 1'b0;
		else if (cnt == HALF - 1) ext_clk <= !ext_clk;
	end
endmodule

// ### sim/tb_clock_monitor_enable_reset_ctrl.sv
// Purpose: self-checking bench for the clock, enable and reset control
// Assumes: watched clock at a quarter of the core clock, short timeout
// Notes: tests run in order and share register state
`timescale 1ns/1ps
module tb_clock_monitor_enable_reset_ctrl;
	localparam logic [15:0] VER = {1'b0, clkctl_pkg::VERSION_ID};
	localparam logic [15:0] VER_WD = {1'b1, clkctl_pkg::VERSION_ID};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic run = 1'b1;
	logic rst_req = 1'b0;
	logic enable_pin = 1'b1;
	logic diag_fault = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ext_clk, ext_reset_n, flt_o, flt_oe, sys_clk_en, internal_reset;
	logic [15:0] reg_rdata;
	logic [1:0] stage_enable;
	logic count_on = 1'b0;
	int pulses = 0;
	int pulses_base = 0;
	int err_count = 0;
	int samples_checked = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk) if (count_on) pulses <= pulses + int'(sys_clk_en);
	host_clock_source #(.HALF(2)) i_host (.clk(clk), .run(run), .rst_req(rst_req),
		.ext_clk(ext_clk), .ext_reset_n(ext_reset_n));
	clock_monitor_enable_reset_ctrl #(.TIMEOUT(16)) i_dut (.clk(clk), .reset(reset),
		.ext_clk(ext_clk), .ext_reset_n(ext_reset_n), .enable_pin(enable_pin),
		.fault_out_n(flt_o), .fault_out_n_oe(flt_oe), .diag_fault(diag_fault),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sys_clk_en(sys_clk_en), .stage_enable(stage_enable),
		.internal_reset(internal_reset));
	task check(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	// One access; read data stands only in the cycle after the strobe
	task rw(input logic w, input logic [3:0] a, input logic [15:0] d, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
		if (!w) check(reg_rdata, e);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task wait_ir(input logic v);
		int i;
		for (i = 0; i < 200 && internal_reset !== v; i++) @(posedge clk);
		if (i == 200) begin
			err_count++;
			$display("CHECK FAILED t=%0t wait ran out", $time);
			tally_and_finish;
		end
	endtask
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		rw(1'b0, clkctl_pkg::OFF_CLK_DIVIDER, 16'h0000, 16'h0008);
		rw(1'b0, clkctl_pkg::OFF_DIAGNOSIS, 16'h0000, 16'h0001);
		rw(1'b0, clkctl_pkg::OFF_DIAGNOSIS, 16'h0000, 16'h0000);
		rw(1'b0, clkctl_pkg::OFF_VERSION, 16'h0000, VER);
		rw(1'b0, 4'hF, 16'h0000, 16'h0000);
		$display("test reset values end");
		rw(1'b1, clkctl_pkg::OFF_SETPOINT0, 16'h8123, 16'h0000);
		rw(1'b1, clkctl_pkg::OFF_CONFIG, 16'h0001, 16'h0000);
		check(stage_enable, 2'b00);
		rw(1'b1, clkctl_pkg::OFF_CLK_DIVIDER, 16'h0004, 16'h0000);
		check(stage_enable, 2'b00);
		rw(1'b1, clkctl_pkg::OFF_CLK_DIVIDER, 16'h8004, 16'h0000);
		check(stage_enable, 2'b01);
		count_on <= 1'b1;
		repeat (160) @(posedge clk);
		count_on <= 1'b0;
		check(pulses >= 9 && pulses <= 11, 1'b1);
		$display("test divider end");
		enable_pin <= 1'b0;
		rw(1'b1, clkctl_pkg::OFF_SETPOINT1, 16'h8055, 16'h0000);
		check(stage_enable, 2'b00);
		check(flt_oe, 1'b1);
		rw(1'b0, clkctl_pkg::OFF_SETPOINT1, 16'h0000, 16'h0055);
		rw(1'b0, clkctl_pkg::OFF_CONFIG, 16'h0000, 16'h0001);
		enable_pin <= 1'b1;
		rw(1'b0, clkctl_pkg::OFF_SETPOINT0, 16'h0000, 16'h0123);
		check(stage_enable, 2'b00);
		check(flt_oe, 1'b0);
		rw(1'b1, clkctl_pkg::OFF_SETPOINT0, 16'h8123, 16'h0000);
		check(stage_enable, 2'b01);
		diag_fault <= 1'b1;
		@(posedge clk);
		#1 check(flt_oe, 1'b1);
		check(flt_o, 1'b0);
		diag_fault <= 1'b0;
		$display("test enable pin end");
		run <= 1'b0;
		wait_ir(1'b1);
		check(flt_oe, 1'b1);
		rw(1'b0, clkctl_pkg::OFF_DIAGNOSIS, 16'h0000, VER_WD);
		rw(1'b1, clkctl_pkg::OFF_CLK_DIVIDER, 16'h8010, 16'h0000);
		run <= 1'b1;
		repeat (20) @(posedge clk);
		rw(1'b1, clkctl_pkg::OFF_CONFIG, 16'h0001, 16'h0000);
		rw(1'b0, clkctl_pkg::OFF_CLK_DIVIDER, 16'h0000, 16'h0008);
		rw(1'b0, clkctl_pkg::OFF_CONFIG, 16'h0000, 16'h0000);
		rw(1'b0, clkctl_pkg::OFF_VERSION, 16'h0000, VER_WD);
		pulses_base = pulses;
		count_on <= 1'b1;
		repeat (160) @(posedge clk);
		count_on <= 1'b0;
		check(pulses - pulses_base >= 4 && pulses - pulses_base <= 6, 1'b1);
		check(internal_reset, 1'b1);
		$display("test watchdog end");
		rst_req <= 1'b1;
		repeat (4) @(posedge clk);
		#1 check(flt_oe, 1'b1);
		rw(1'b0, clkctl_pkg::OFF_VERSION, 16'h0000, 16'h0000);
		rst_req <= 1'b0;
		wait_ir(1'b0);
		rw(1'b0, clkctl_pkg::OFF_VERSION, 16'h0000, VER);
		rw(1'b0, clkctl_pkg::OFF_DIAGNOSIS, 16'h0000, 16'h0001);
		run <= 1'b0;
		repeat (60) @(posedge clk);
		#1 check(internal_reset, 1'b0);
		run <= 1'b1;
		$display("test external reset end");
		tally_and_finish;
	end
endmodule
